// File: verilog/lsa_pkg.sv
// Package: register map, field positions, timing and carrier types for the limit status block
package lsa_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_CFG1 = 8'h40;
  localparam logic [7:0] ADDR_STAT1 = 8'h41;
  localparam logic [7:0] ADDR_STAT2 = 8'h42;
  localparam logic [7:0] ADDR_CFG2 = 8'h73;
  localparam logic [7:0] ADDR_MASK1 = 8'h74;
  localparam logic [7:0] ADDR_MASK2 = 8'h75;
  localparam logic [7:0] ADDR_CFG3 = 8'h78;
  localparam logic [7:0] ADDR_CFG4 = 8'h7D;
  // Latest channel values, one byte per channel from this base
  localparam logic [7:0] ADDR_VAL_BASE = 8'h20;
  // Reset values
  localparam logic [7:0] CFG1_RST = 8'h01;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'h00;
  localparam logic [7:0] CFG4_RST = 8'h01;
  localparam logic [7:0] VAL_RST = 8'h00;
  // Field positions
  localparam int CFG1_START = 0;
  localparam int CFG2_NOAVG = 4;
  localparam int CFG3_ALERT = 0;
  localparam int CFG3_OVERTEMP_PIN_EN = 1;
  localparam int ST1_OOL = 7;
  localparam int ST2_F4 = 5;
  localparam int ST2_OVT = 1;
  localparam int ST2_STICKY_LO = 2;
  localparam int ST2_STICKY_HI = 7;
  localparam int MASK1_OOL = 7;
  // Analog channels in round-robin order: core, supply, remote 1, local, remote 2
  localparam int NCH = 5;
  localparam int CH_BIT [NCH] = '{1, 2, 4, 5, 6};
  // Source bits of each status register (reserved bits excluded)
  localparam logic [7:0] ST1_SRC = 8'h76;
  localparam logic [7:0] ST2_SRC = 8'hFE;
  // Monitoring pass time
  localparam int CLK_KHZ = 25000;
  localparam int PASS_AVG_MS = 146;
  localparam int PASS_FAST_MS = 19;
  localparam int PASS_AVG_CYC = PASS_AVG_MS * CLK_KHZ;
  localparam int PASS_FAST_CYC = PASS_FAST_MS * CLK_KHZ;
  // Role of the second multifunction pin
  typedef enum logic [1:0] {
    ROLE_OVERTEMP_PIN = 2'b00,
    ROLE_FAN_FOUR_TACH_INPUT = 2'b01,
    ROLE_GPIO = 2'b10,
    ROLE_ALERT = 2'b11
  } pin_role_t;
  // One finished conversion with the limits it is judged against
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [7:0] value;
    logic [7:0] low;
    logic [7:0] high;
  } meas_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// File: verilog/cycle_sequencer.sv
// Round-robin conversion sequencer: paces one conversion request per channel slot
`timescale 1ns/100ps
module cycle_sequencer import lsa_pkg::*; #(
  parameter int SLOT_AVG = PASS_AVG_CYC / NCH,
  parameter int SLOT_FAST = PASS_FAST_CYC / NCH,
  parameter int CNT_W = 22
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic fast,
  output logic conv_req,
  output logic [2:0] conv_chan
);
  initial begin
    if (SLOT_AVG < 1 || SLOT_FAST < 1 || SLOT_AVG >= 2 ** CNT_W || SLOT_FAST >= 2 ** CNT_W) begin
      $error("slot length does not fit the counter");
    end
  end
  logic [CNT_W-1:0] cnt_reg; // Cycles left in the current slot
  logic [2:0] chan_reg; // Channel of the next request
  wire slot_end = (cnt_reg == '0);
  wire [CNT_W-1:0] reload = fast ? CNT_W'(SLOT_FAST - 1) : CNT_W'(SLOT_AVG - 1);
  wire [2:0] chan_next = (chan_reg == 3'(NCH - 1)) ? 3'h0 : chan_reg + 3'h1;
  // A stop lets the running slot finish but starts nothing new
  assign conv_req = run && slot_end;
  assign conv_chan = chan_reg;
  // Slot counter: five slots make one pass of the chosen length
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      chan_reg <= 3'h0;
    end else if (conv_req) begin
      cnt_reg <= reload;
      chan_reg <= chan_next;
    end else if (!slot_end) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  // Helper: cycles since the previous request
  logic [CNT_W:0] gap_reg;
  logic seen_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= conv_req ? (CNT_W+1)'(1) : gap_reg + 1'b1;
      seen_reg <= seen_reg | conv_req;
    end
  end
  chk_stop_halts: assert property (@(posedge clk) disable iff (!rstn) !run |-> !conv_req)
    else $error("request issued while stopped");
  chk_slot_gap: assert property (@(posedge clk) disable iff (!rstn)
    conv_req && seen_reg && $past(run) |-> gap_reg == SLOT_AVG || gap_reg == SLOT_FAST || gap_reg > SLOT_AVG)
    else $error("slot spacing wrong");
  chk_chan_wrap: assert property (@(posedge clk) disable iff (!rstn)
    conv_req && conv_chan == 3'(NCH - 1) |=> conv_chan == 3'h0)
    else $error("channel order broken");
  cov_fast_req: cover property (@(posedge clk) disable iff (!rstn) conv_req && fast);
endmodule

// File: verilog/sticky_flag.sv
// One status bit: set by its source, cleared by a read only once the cause has gone
`timescale 1ns/100ps
module sticky_flag (
  input wire logic clk,
  input wire logic rstn,
  input wire logic set_evt,
  input wire logic cond_now,
  input wire logic rd_clr,
  output logic flag
);
  logic flag_reg;
  // Set wins over a clearing read in the same cycle, so no event is lost
  wire flag_next = set_evt | (flag_reg & ~(rd_clr & ~cond_now));
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
  assign flag = flag_reg;
  chk_read_keeps: assert property (@(posedge clk) disable iff (!rstn)
    flag && rd_clr && cond_now |=> flag)
    else $error("flag cleared while condition persists");
  chk_hold_noread: assert property (@(posedge clk) disable iff (!rstn)
    flag && !rd_clr |=> flag)
    else $error("flag dropped without a read");
  chk_set_event: assert property (@(posedge clk) disable iff (!rstn) set_evt |=> flag)
    else $error("flag not set by event");
  cov_read_clear: cover property (@(posedge clk) disable iff (!rstn) flag && rd_clr && !cond_now ##1 !flag);
endmodule

// File: verilog/limit_status_alert_logic.sv
// Limit status, alert masking and multifunction pin selection for the thermal monitor
//
// Functional notes
// - Start bit begins monitoring, set after reset
// - Clearing start bit stops further conversions
// - Each result stored at once per channel
// - Averaged pass takes 146 ms
// - Unaveraged pass takes 19 ms
// - Fan flags independent of analog cycle
// - Out-of-limit comparison sets channel status bit
// - Sticky bits clear by read after cause
// - Overtemperature bit and its alert self-clear
// - Summary bit shows second status register nonzero
// - First status bit map per channel
// - Second status: diodes, fans, overtemperature
// - Bit five is fan four or timer
// - Masks gate alert only, not status
// - Alert stays low until status read
// - Mask bit map blocks matching source
// - Mask one bit seven gates register-two summary
// - Mask two bit five follows pin role
// - Alert off at reset, config three enables
// - Config four selects second pin role
// - Out when above high or at/below low
// - Config two bit four disables averaging
`timescale 1ns/100ps
module limit_status_alert_logic import lsa_pkg::*; #(
  parameter int PASS_AVG = PASS_AVG_CYC, // Averaged pass length in cycles
  parameter int PASS_FAST = PASS_FAST_CYC, // Unaveraged pass length in cycles
  parameter int CNT_W = 22 // Slot counter width
) (
  input wire logic clk,
  input wire logic rstn,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic conv_req,
  output logic [2:0] conv_chan,
  input wire meas_t meas,
  input wire logic [1:0] diode_fault,
  input wire logic [3:0] fan_slow,
  input wire logic timer_limit_hit,
  input wire logic overtemp_active,
  output logic pin_one_o,
  output logic pin_one_oe,
  input wire logic pin_two_i,
  output logic pin_two_o,
  output logic pin_two_oe,
  output logic fan_four_tach_input,
  output logic overtemp_pin,
  output logic averaging_on
);
  initial begin
    if (PASS_AVG < NCH || PASS_FAST < NCH) begin
      $error("pass length shorter than one cycle per channel");
    end
  end

  // Software-visible configuration
  logic [7:0] cfg1_reg; // Start bit lives here
  logic [7:0] cfg2_reg; // Averaging control
  logic [7:0] mask1_reg; // Alert masks for analog channels
  logic [7:0] mask2_reg; // Alert masks for diodes, fans, overtemperature
  logic [7:0] cfg3_reg; // Alert enable on pin one, timer enable
  logic [7:0] cfg4_reg; // Role of pin two
  logic [7:0] val_reg [NCH]; // Latest value of each channel
  logic [NCH-1:0] last_out_reg; // Result of last comparison per channel
  logic ovt_reg; // Non-sticky overtemperature bit
  logic [7:0] rdata_reg;
  logic io_tach_reg;
  logic io_overtemp_pin_reg;

  // Register decode
  wire wr_cfg1 = reg_req.wr && reg_req.addr == ADDR_CFG1;
  wire wr_cfg2 = reg_req.wr && reg_req.addr == ADDR_CFG2;
  wire wr_mask1 = reg_req.wr && reg_req.addr == ADDR_MASK1;
  wire wr_mask2 = reg_req.wr && reg_req.addr == ADDR_MASK2;
  wire wr_cfg3 = reg_req.wr && reg_req.addr == ADDR_CFG3;
  wire wr_cfg4 = reg_req.wr && reg_req.addr == ADDR_CFG4;
  wire rd_stat1 = reg_req.rd && reg_req.addr == ADDR_STAT1;
  wire rd_stat2 = reg_req.rd && reg_req.addr == ADDR_STAT2;

  // Pin two role and derived modes
  pin_role_t role;
  assign role = pin_role_t'(cfg4_reg[1:0]);
  // Timer role needs both the role code and the enable bit
  wire overtemp_pin_mode = (role == ROLE_OVERTEMP_PIN) && cfg3_reg[CFG3_OVERTEMP_PIN_EN];
  wire fast_mode = cfg2_reg[CFG2_NOAVG];

  // Sequencer: one slot per channel; slot sums to the pass time
  cycle_sequencer #(
    .SLOT_AVG(PASS_AVG / NCH),
    .SLOT_FAST(PASS_FAST / NCH),
    .CNT_W(CNT_W)
  ) u_seq (
    .clk(clk),
    .rstn(rstn),
    .run(cfg1_reg[CFG1_START]),
    .fast(fast_mode),
    .conv_req(conv_req),
    .conv_chan(conv_chan)
  );

  // Window comparison: strictly above high or at/below low is out
  wire meas_ok = meas.valid && meas.chan < 3'(NCH);
  wire meas_out = (meas.value > meas.high) || (meas.value <= meas.low);

  // Analog channel status bits
  logic [NCH-1:0] ch_flag;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire hit = meas_ok && meas.chan == 3'(g);
      sticky_flag u_flag (
        .clk(clk),
        .rstn(rstn),
        .set_evt(hit && meas_out),
        .cond_now(hit ? meas_out : last_out_reg[g]),
        .rd_clr(rd_stat1),
        .flag(ch_flag[g])
      );
    end
  endgenerate

  // Second register sources are levels from the tach and diode logic,
  // which run free of the analog cycle
  wire f4_src = overtemp_pin_mode ? timer_limit_hit : fan_slow[3];
  wire [7:0] src2 = {diode_fault[1], diode_fault[0], f4_src, fan_slow[2:0], 2'b00};
  logic [7:0] stat2_sticky;
  generate
    for (g = 0; g < 8; g++) begin : g_st2
      if (g >= ST2_STICKY_LO && g <= ST2_STICKY_HI) begin : g_on
        sticky_flag u_flag (
          .clk(clk),
          .rstn(rstn),
          .set_evt(src2[g]),
          .cond_now(src2[g]),
          .rd_clr(rd_stat2),
          .flag(stat2_sticky[g])
        );
      end else begin : g_off
        assign stat2_sticky[g] = 1'b0;
      end
    end
  endgenerate

  // Assemble the status registers
  logic [7:0] stat1;
  logic [7:0] stat2;
  always_comb begin
    stat2 = stat2_sticky;
    stat2[ST2_OVT] = ovt_reg;
    stat1 = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      stat1[CH_BIT[i]] = ch_flag[i];
    end
    stat1[ST1_OOL] = |stat2;
  end

  // Alert: any unmasked source bit pulls the line low, the summary bit only once every register-two source is masked; masks never touch status
  wire [7:0] live1 = stat1 & ~mask1_reg & ST1_SRC;
  wire [7:0] live2 = stat2 & ~mask2_reg & ST2_SRC;
  // With every second-register source masked, the summary mask decides
  wire all2_masked = &mask2_reg[ST2_STICKY_HI:ST2_OVT];
  wire summary_alert = all2_masked && (|stat2) && !mask1_reg[MASK1_OOL];
  wire alert_pending = (|live1) || (|live2) || summary_alert;

  // Open-drain outputs: only ever drive low
  assign pin_one_o = 1'b0;
  assign pin_one_oe = cfg3_reg[CFG3_ALERT] && alert_pending;
  assign pin_two_o = 1'b0;
  assign pin_two_oe = (role == ROLE_ALERT) && alert_pending;
  assign fan_four_tach_input = io_tach_reg;
  assign overtemp_pin = io_overtemp_pin_reg;
  assign averaging_on = !fast_mode;
  assign reg_rdata = rdata_reg;

  // Read multiplexer; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_req.addr)
      ADDR_CFG1: rd_mux = cfg1_reg;
      ADDR_STAT1: rd_mux = stat1;
      ADDR_STAT2: rd_mux = stat2;
      ADDR_CFG2: rd_mux = cfg2_reg;
      ADDR_MASK1: rd_mux = mask1_reg;
      ADDR_MASK2: rd_mux = mask2_reg;
      ADDR_CFG3: rd_mux = cfg3_reg;
      ADDR_CFG4: rd_mux = cfg4_reg;
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (reg_req.addr == ADDR_VAL_BASE + 8'(i)) begin
            rd_mux = val_reg[i];
          end
        end
      end
    endcase
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg1_reg <= CFG1_RST;
      cfg2_reg <= CFG2_RST;
      mask1_reg <= MASK_RST;
      mask2_reg <= MASK_RST;
      cfg3_reg <= CFG3_RST;
      cfg4_reg <= CFG4_RST;
    end else begin
      if (wr_cfg1) cfg1_reg <= reg_req.wdata;
      if (wr_cfg2) cfg2_reg <= reg_req.wdata;
      if (wr_mask1) mask1_reg <= reg_req.wdata;
      if (wr_mask2) mask2_reg <= reg_req.wdata;
      if (wr_cfg3) cfg3_reg <= reg_req.wdata;
      if (wr_cfg4) cfg4_reg <= reg_req.wdata;
    end
  end

  // Value store and last comparison, written as each result lands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        val_reg[i] <= VAL_RST;
      end
      last_out_reg <= '0;
    end else if (meas_ok) begin
      val_reg[meas.chan] <= meas.value;
      last_out_reg[meas.chan] <= meas_out;
    end
  end

  // Overtemperature follows its source, read data and pin inputs are registered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ovt_reg <= 1'b0;
      rdata_reg <= 8'h00;
      io_tach_reg <= 1'b0;
      io_overtemp_pin_reg <= 1'b0;
    end else begin
      ovt_reg <= overtemp_active;
      if (reg_req.rd) rdata_reg <= rd_mux;
      io_tach_reg <= (role == ROLE_FAN_FOUR_TACH_INPUT) && pin_two_i;
      io_overtemp_pin_reg <= overtemp_pin_mode && !pin_two_i;
    end
  end

  // Checks
  chk_start_reset: assert property (@(posedge clk) $past(!rstn) && rstn |-> cfg1_reg[CFG1_START])
    else $error("start bit not set after reset");
  chk_value_store: assert property (@(posedge clk) disable iff (!rstn)
    meas_ok |=> val_reg[$past(meas.chan)] == $past(meas.value))
    else $error("result not stored");
  chk_flag_sets: assert property (@(posedge clk) disable iff (!rstn)
    meas_ok && (meas.value <= meas.low) |=> stat1[CH_BIT[$past(meas.chan)]])
    else $error("low limit hit not flagged");
  chk_ovt_clears: assert property (@(posedge clk) disable iff (!rstn)
    !overtemp_active |=> !stat2[ST2_OVT])
    else $error("overtemperature bit stuck");
  chk_summary_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_stat1 && (|stat2) |=> reg_rdata[ST1_OOL])
    else $error("summary bit missing on read");
  chk_alert_drive: assert property (@(posedge clk) disable iff (!rstn)
    cfg3_reg[CFG3_ALERT] && (|live1) |-> pin_one_oe && !pin_one_o)
    else $error("alert not driven");
  chk_alert_off: assert property (@(posedge clk) disable iff (!rstn)
    !cfg3_reg[CFG3_ALERT] |-> !pin_one_oe)
    else $error("alert driven while disabled");
  chk_pin_two_role: assert property (@(posedge clk) disable iff (!rstn)
    role != ROLE_ALERT |-> !pin_two_oe)
    else $error("pin two driven outside alert role");
  chk_mask_block: assert property (@(posedge clk) disable iff (!rstn)
    ((stat1 & ~mask1_reg & ST1_SRC) == 8'h00) && ((stat2 & ~mask2_reg & ST2_SRC) == 8'h00)
    && mask1_reg[MASK1_OOL] |-> !pin_one_oe && !pin_two_oe)
    else $error("masked source drove alert");
  cov_alert: cover property (@(posedge clk) disable iff (!rstn) $rose(pin_one_oe));
  cov_ovt: cover property (@(posedge clk) disable iff (!rstn) stat2[ST2_OVT] ##1 !stat2[ST2_OVT]);
  cov_timer_flag: cover property (@(posedge clk) disable iff (!rstn) overtemp_pin_mode && stat2[ST2_F4]);
endmodule

// File: test/conv_model.sv
// Behavioural converter front end that answers each conversion request with one result
`timescale 1ns/100ps
module conv_model import lsa_pkg::*; #(
  parameter int LAT = 3 // Request to result in cycles; must stay under the fast slot
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic conv_req,
  input wire logic [2:0] conv_chan,
  input wire logic [7:0] val_tab [NCH],
  input wire logic [7:0] lim_lo,
  input wire logic [7:0] lim_hi,
  output meas_t meas
);
  logic [2:0] ch_reg; // Channel under conversion
  int cnt; // Cycles left to the result, 0 when idle
  // Take a request, count out the latency, then pulse the result once
  always @(posedge clk) begin
    if (!rstn) begin
      cnt <= 0;
      ch_reg <= '0;
      meas <= '0;
    end else begin
      // One assignment per edge: a result pulse, or an idle bus whose value keeps
      // changing so that a late sample cannot pass by luck
      if (!conv_req && cnt == 1) begin
        meas <= meas_t'{1'b1, ch_reg, val_tab[ch_reg], lim_lo, lim_hi};
      end else begin
        meas <= meas_t'{1'b0, meas.chan, ~meas.value, meas.low, meas.high};
      end
      if (conv_req) begin
        ch_reg <= conv_chan;
        cnt <= LAT;
      end else if (cnt == 1) begin
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: test/tb_limit_status_alert_logic.sv
// Self-checking bench for the limit status, alert and pin selection block
`timescale 1ns/100ps
module tb_limit_status_alert_logic import lsa_pkg::*; ();
  localparam int PA = 50; // Short averaged pass
  localparam int PF = 25; // Short fast pass
  logic clk;
  logic rstn = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic conv_req;
  logic [2:0] conv_chan;
  meas_t meas;
  logic [1:0] diode_fault = '0;
  logic [3:0] fan_slow = '0;
  logic timer_limit_hit = 1'b0;
  logic overtemp_active = 1'b0;
  logic pin_two_i = 1'b1;
  logic pin_one_o, pin_one_oe, pin_two_o, pin_two_oe, fan_four_tach_input, overtemp_pin, averaging_on;
  // Channel 0 above high, 1 at high, 2 at low, 3 just above low, 4 below low
  logic [7:0] val_tab [NCH] = '{8'hC9, 8'hC8, 8'h0A, 8'h0B, 8'h05};
  int failures = 0;
  int n_checks = 0;
  logic [7:0] d;
  logic [2:0] ch;
  logic [2:0] ch2;
  int n;

  // Free-running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  limit_status_alert_logic #(.PASS_AVG(PA), .PASS_FAST(PF), .CNT_W(22)) DUT (.clk(clk), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_req(conv_req), .conv_chan(conv_chan), .meas(meas),
    .diode_fault(diode_fault), .fan_slow(fan_slow), .timer_limit_hit(timer_limit_hit),
    .overtemp_active(overtemp_active), .pin_one_o(pin_one_o), .pin_one_oe(pin_one_oe), .pin_two_i(pin_two_i),
    .pin_two_o(pin_two_o), .pin_two_oe(pin_two_oe), .fan_four_tach_input(fan_four_tach_input),
    .overtemp_pin(overtemp_pin), .averaging_on(averaging_on));

  conv_model #(.LAT(3)) u_conv (.clk(clk), .rstn(rstn), .conv_req(conv_req), .conv_chan(conv_chan),
    .val_tab(val_tab), .lim_lo(8'h0A), .lim_hi(8'hC8), .meas(meas));

  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Byte compare
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Single-bit compare
  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe; a spare edge first keeps back-to-back calls clean
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = v;
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask

  // One-cycle read strobe; data is settled half a cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clk);
    reg_req.rd = 1'b0;
    v = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk8(v, e, "register read");
  endtask

  // Next conversion request, with the cycles waited; bounded
  task automatic wait_req(output logic [2:0] c, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (conv_req !== 1'b1 && k < 2000);
    if (conv_req !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no conversion request", $time);
      close_out();
    end
    c = conv_chan;
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Main sequence
  initial begin
    step(6);
    rstn = 1'b1;
    chk1(pin_one_oe, 1'b0, "alert off at reset");
    chk1(averaging_on, 1'b1, "averaging at reset");
    rdchk(ADDR_CFG1, CFG1_RST);
    rdchk(ADDR_CFG4, CFG4_RST);
    rdchk(ADDR_MASK1, MASK_RST);
    rdchk(ADDR_CFG3, CFG3_RST);
    rdchk(8'h10, 8'h00);
    // Order of channels and slot length, averaged
    wait_req(ch, n);
    for (int i = 0; i < NCH + 1; i++) begin
      wait_req(ch2, n);
      chk8({5'h00, ch2}, (ch == 3'd4) ? 8'h00 : {5'h00, ch + 3'd1}, "channel order");
      chk8(8'(n), 8'(PA / NCH), "averaged slot");
      ch = ch2;
    end
    step(2 * PA);
    for (int i = 0; i < NCH; i++) begin
      rdchk(ADDR_VAL_BASE + 8'(i), val_tab[i]);
    end
    rdchk(ADDR_STAT1, 8'h52);
    rdchk(ADDR_STAT1, 8'h52);
    // Cause gone: first read still shows it, the next one does not
    val_tab[0] = 8'h64;
    step(2 * PA);
    rdchk(ADDR_STAT1, 8'h52);
    rdchk(ADDR_STAT1, 8'h50);
    // Fast pass
    wr(ADDR_CFG2, 8'h10);
    chk1(averaging_on, 1'b0, "averaging off");
    wait_req(ch, n);
    wait_req(ch, n);
    wait_req(ch, n);
    chk8(8'(n), 8'(PF / NCH), "fast slot");
    // Second status register sources
    diode_fault = 2'b11;
    fan_slow = 4'hF;
    overtemp_active = 1'b1;
    step(3);
    rdchk(ADDR_STAT2, 8'hFE);
    rdchk(ADDR_STAT1, 8'hD0);
    diode_fault = 2'b00;
    fan_slow = 4'h0;
    overtemp_active = 1'b0;
    step(3);
    rdchk(ADDR_STAT2, 8'hFC);
    rdchk(ADDR_STAT2, 8'h00);
    rdchk(ADDR_STAT1, 8'h50);
    // Alert on pin one; analog sources stay masked
    wr(ADDR_MASK1, 8'h76);
    fan_slow = 4'h1;
    step(3);
    chk1(pin_one_oe, 1'b0, "alert disabled");
    wr(ADDR_CFG3, 8'h01);
    chk1(pin_one_oe, 1'b1, "alert asserted");
    chk1(pin_one_o, 1'b0, "alert pin level");
    wr(ADDR_MASK2, 8'h04);
    chk1(pin_one_oe, 1'b0, "fan masked");
    rdchk(ADDR_STAT2, 8'h04);
    wr(ADDR_MASK2, 8'hFE);
    chk1(pin_one_oe, 1'b1, "summary path open");
    wr(ADDR_MASK1, 8'hF6);
    chk1(pin_one_oe, 1'b0, "summary path masked");
    wr(ADDR_MASK1, 8'h76);
    wr(ADDR_MASK2, 8'h00);
    fan_slow = 4'h0;
    step(4);
    chk1(pin_one_oe, 1'b1, "alert held until read");
    rd(ADDR_STAT2, d);
    chk1(pin_one_oe, 1'b0, "alert released by read");
    overtemp_active = 1'b1;
    step(2);
    chk1(pin_one_oe, 1'b1, "overtemperature alert");
    overtemp_active = 1'b0;
    step(2);
    chk1(pin_one_oe, 1'b0, "overtemperature alert gone");
    // Roles of pin two
    wr(ADDR_CFG4, 8'h03);
    overtemp_active = 1'b1;
    step(2);
    chk1(pin_two_oe, 1'b1, "pin two alert");
    chk1(pin_two_o, 1'b0, "pin two alert level");
    wr(ADDR_CFG4, 8'h02);
    chk1(pin_two_oe, 1'b0, "pin two general purpose");
    overtemp_active = 1'b0;
    wr(ADDR_CFG4, 8'h01);
    step(2);
    chk1(fan_four_tach_input, 1'b1, "pin two tach");
    wr(ADDR_CFG4, 8'h00);
    wr(ADDR_CFG3, 8'h03);
    pin_two_i = 1'b0;
    step(2);
    chk1(overtemp_pin, 1'b1, "pin two timer input");
    rd(ADDR_STAT2, d);
    // Timer role: bit five follows the timer, not fan four
    fan_slow = 4'h8;
    step(3);
    rdchk(ADDR_STAT2, 8'h00);
    wr(ADDR_MASK2, 8'h20);
    timer_limit_hit = 1'b1;
    step(3);
    chk1(pin_one_oe, 1'b0, "timer masked");
    rdchk(ADDR_STAT2, 8'h20);
    timer_limit_hit = 1'b0;
    fan_slow = 4'h0;
    // Stop monitoring: the running slot may finish, then silence
    wr(ADDR_CFG1, 8'h00);
    step(PA / NCH + 5);
    n = 0;
    repeat (3 * PA) begin
      @(negedge clk);
      if (conv_req === 1'b1) n++;
    end
    chk8(8'(n), 8'h00, "requests after stop");
    fan_slow = 4'h2;
    step(3);
    rdchk(ADDR_STAT2, 8'h28);
    close_out();
  end
endmodule
